// ==== src/asf_params.svh ====
// constants for the conversion status flag block
`ifndef ASF_PARAMS_SVH
`define ASF_PARAMS_SVH

// register addresses in the command byte
`define ASF_ADDR_STATUS 6'h00
`define ASF_ADDR_MODE 6'h01
`define ASF_ADDR_DATA 6'h04

// status register reset and field positions
`define ASF_STATUS_RESET 8'h80
`define ASF_BIT_RDY 7
`define ASF_BIT_ADC_ERR 6
`define ASF_BIT_CRC_ERR 5
`define ASF_BIT_REG_ERR 4
`define ASF_CHAN_MSB 3

// command byte fields
`define ASF_CMD_BIT_WEN 7
`define ASF_CMD_BIT_READ 6

// frame lengths in serial clocks, minus one
`define ASF_LAST_CMD 6'h07
`define ASF_LAST_STAT 6'h07
`define ASF_LAST_DATA 6'h17
`define ASF_LAST_DATA_ST 6'h1F
`define ASF_LAST_MODE 6'h0F

// result clamp codes
`define ASF_CLAMP_HI 24'hFFFFFF
`define ASF_CLAMP_LO 24'h000000

`endif

// ==== src/asf_pkg.sv ====
// types shared by the conversion status flag block
package asf_pkg;

    // serial link transaction states
    typedef enum logic [2:0] {
        ASF_CMD,
        ASF_RD_STAT,
        ASF_RD_DATA,
        ASF_WR_MODE,
        ASF_SKIP_RD,
        ASF_SKIP
    } asf_link_e;

    // conversion result as presented by the datapath
    typedef struct packed {
        logic ovr;
        logic unr;
        logic [3:0] chan;
        logic [23:0] code;
    } asf_result_s;

    // status register layout
    typedef struct packed {
        logic rdy;
        logic adc_err;
        logic crc_err;
        logic reg_err;
        logic [3:0] chan;
    } asf_status_s;

endpackage : asf_pkg

// ==== src/asf_status.sv ====
// conversion status register with its serial read path
//
// Summary of operation
// R01: ready flag on data-out while idle selected
// R02: new result clears ready flag
// R03: calibration mode: calibration result clears ready
// R04: data register read sets ready flag
// R05: clamp out-of-range result, flag range error
// R06: range flag updates only on result write
// R07: failing write CRC sets CRC error
// R08: status read clears CRC error
// R09: host checks read CRC itself
// R10: integrity mismatch sets register error flag
// R11: register error clears only with check off
// R12: channel field names held result's channel
// R13: channel coded plainly in binary
// R14: append status byte after data when enabled
// R15: status at address zero, resets 0x80
// R16: every access starts with command byte
// R17: mode register write sets ready flag
// R18: status read returns CRC flag before clear
`timescale 1ns/1ns
`default_nettype none
`include "asf_params.svh"

module asf_status (
    input wire logic clk_sys_in, // device clock
    input wire logic reset_n_in, // async reset, active low
    input wire logic sclk_in, // serial clock from host
    input wire logic cs_n_in, // chip select, active low
    input wire logic din_in, // serial data from host
    output logic dout_out, // data-out / ready pin
    output logic dout_oe_out, // pin drive enable
    input wire asf_pkg::asf_result_s result_in, // new result
    input wire logic result_wr_in, // result written strobe
    input wire logic cal_mode_in, // calibration mode active
    input wire logic cal_done_in, // calibration written strobe
    input wire logic crc_fail_in, // write CRC failed strobe
    input wire logic reg_check_en_in, // integrity check on
    input wire logic reg_mismatch_in, // integrity mismatch
    input wire logic data_stat_en_in, // append status option
    output asf_pkg::asf_status_s status_out, // status register
    output logic [23:0] data_out, // clamped data register
    output logic mode_wr_out // mode write seen, pulse
);
    import asf_pkg::*;

    localparam int NEV = 3;
    localparam int EV_STAT = 0;
    localparam int EV_DATA = 1;
    localparam int EV_MODE = 2;

    // ---------------- device clock domain, except tog_r ----------------
    logic [1:0] rst_pipe_r;
    logic rst_n;
    logic cs_meta_r;
    logic cs_sync_r;
    logic [NEV-1:0] tog_r;
    logic [NEV-1:0] tog_meta_r;
    logic [NEV-1:0] tog_sync_r;
    logic [NEV-1:0] tog_last_r;
    logic [NEV-1:0] ev;
    logic rdy_r;
    logic adc_err_r;
    logic crc_err_r;
    logic reg_err_r;
    logic [3:0] chan_r;
    logic [23:0] data_r;
    logic mode_wr_r;
    logic [32:0] snap_r;
    logic new_result;
    logic res_upd;
    asf_status_s status;

    // ---------------- serial clock domain ----------------
    asf_link_e st_r;
    logic [5:0] cnt_r;
    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic [NEV-1:0] fire;
    logic rd_on_r;
    logic out_r;

    // last bit count of the transfer that follows the command byte
    function automatic logic [5:0] last_bit(input asf_link_e s,
                                            input logic stat_en);
        unique case (s)
            ASF_RD_STAT: last_bit = `ASF_LAST_STAT;
            ASF_RD_DATA: last_bit = stat_en ? `ASF_LAST_DATA_ST
                                            : `ASF_LAST_DATA;
            ASF_WR_MODE: last_bit = `ASF_LAST_MODE;
            default: last_bit = `ASF_LAST_CMD;
        endcase
    endfunction : last_bit

    // states in which the pin carries register bits
    function automatic logic is_read(input asf_link_e s);
        return (s == ASF_RD_STAT) || (s == ASF_RD_DATA);
    endfunction : is_read

    // reset release through two flip-flops
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_pipe_r <= 2'h0;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_r[1];

    // chip select synchroniser
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            cs_meta_r <= 1'b1;
            cs_sync_r <= 1'b1;
        end else begin
            cs_meta_r <= cs_n_in;
            cs_sync_r <= cs_meta_r;
        end
    end

    // toggle events from the link, two flops then edge
    // a toggle rather than a pulse, so a short serial frame
    // cannot slip between two device clock edges unseen
    generate
        for (genvar i = 0; i < NEV; i++) begin : g_ev
            always_ff @(posedge clk_sys_in or negedge rst_n) begin
                if (!rst_n) begin
                    tog_meta_r[i] <= 1'b0;
                    tog_sync_r[i] <= 1'b0;
                    tog_last_r[i] <= 1'b0;
                end else begin
                    tog_meta_r[i] <= tog_r[i];
                    tog_sync_r[i] <= tog_meta_r[i];
                    tog_last_r[i] <= tog_sync_r[i];
                end
            end
            assign ev[i] = tog_sync_r[i] ^ tog_last_r[i];
        end
    endgenerate

    // which strobe marks a fresh result
    assign new_result = cal_mode_in ? cal_done_in
                                    : result_wr_in; // R03
    assign res_upd = result_wr_in & ~cal_mode_in;

    // ready flag: new result wins over a set
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            rdy_r <= 1'(`ASF_STATUS_RESET >> `ASF_BIT_RDY); // R15
        end else if (new_result) begin
            rdy_r <= 1'b0; // R02
        end else if (ev[EV_DATA]) begin
            rdy_r <= 1'b1; // R04
        end else if (ev[EV_MODE]) begin
            rdy_r <= 1'b1; // R17
        end
    end

    // range flag and held channel, only on result write
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            adc_err_r <= 1'b0;
            chan_r <= 4'h0;
        end else if (res_upd) begin
            adc_err_r <= result_in.ovr | result_in.unr; // R06
            chan_r <= result_in.chan; // R12 R13
        end
    end

    // clamped data register
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            data_r <= `ASF_CLAMP_LO;
        end else if (res_upd) begin
            if (result_in.ovr) begin
                data_r <= `ASF_CLAMP_HI; // R05
            end else if (result_in.unr) begin
                data_r <= `ASF_CLAMP_LO; // R05
            end else begin
                data_r <= result_in.code;
            end
        end
    end

    // write CRC flag: a failure beats the read clear
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            crc_err_r <= 1'b0;
        end else if (crc_fail_in) begin
            crc_err_r <= 1'b1; // R07
        end else if (ev[EV_STAT]) begin
            crc_err_r <= 1'b0; // R08 R18
        end
    end

    // integrity flag, cleared only by turning the check off
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_err_r <= 1'b0;
        end else if (!reg_check_en_in) begin
            reg_err_r <= 1'b0; // R11
        end else if (reg_mismatch_in) begin
            reg_err_r <= 1'b1; // R10
        end
    end

    // mode write pulse for the filter restart
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            mode_wr_r <= 1'b0;
        end else begin
            mode_wr_r <= ev[EV_MODE]; // R17
        end
    end

    // status assembly
    always_comb begin
        status.rdy = rdy_r;
        status.adc_err = adc_err_r;
        status.crc_err = crc_err_r;
        status.reg_err = reg_err_r;
        status.chan = chan_r;
    end

    // read snapshot, frozen while the frame is open
    // the link side reads it only while chip select is low, so
    // it never changes under the serial clock; the host must
    // leave a few device clocks after selecting before bits move
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            snap_r <= {1'b0, `ASF_CLAMP_LO, `ASF_STATUS_RESET};
        end else if (cs_sync_r) begin
            snap_r <= {data_stat_en_in, data_r, status}; // R18
        end
    end

    assign status_out = status;
    assign data_out = data_r;
    assign mode_wr_out = mode_wr_r;

    // ---------------- link logic on the serial clock ----------------
    // everything here is cleared while chip select is high, except
    // the event toggles; the serial clock only runs inside frames,
    // so a frame cut short simply leaves the machine in reset

    // incoming bits, most significant first
    assign sh_nxt = {sh_r[6:0], din_in};

    // command decode and transaction length, ended by chip select
    // a command byte with its top bit set is dropped and the next
    // eight clocks are taken as a fresh command
    always_ff @(posedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            st_r <= ASF_CMD;
            cnt_r <= 6'h00;
            sh_r <= 8'h00;
        end else begin
            sh_r <= sh_nxt;
            unique case (st_r)
                ASF_CMD: begin
                    if (cnt_r == `ASF_LAST_CMD) begin
                        cnt_r <= 6'h00;
                        if (sh_nxt[`ASF_CMD_BIT_WEN]) begin
                            st_r <= ASF_CMD; // R16
                        end else if (sh_nxt[`ASF_CMD_BIT_READ]) begin
                            if (sh_nxt[5:0] == `ASF_ADDR_STATUS) begin
                                st_r <= ASF_RD_STAT; // R15 R16
                            end else if (sh_nxt[5:0] == `ASF_ADDR_DATA) begin
                                st_r <= ASF_RD_DATA;
                            end else begin
                                st_r <= ASF_SKIP_RD;
                            end
                        end else if (sh_nxt[5:0] == `ASF_ADDR_MODE) begin
                            st_r <= ASF_WR_MODE;
                        end else begin
                            st_r <= ASF_SKIP;
                        end
                    end else begin
                        cnt_r <= cnt_r + 6'h01;
                    end
                end
                ASF_RD_STAT, ASF_RD_DATA, ASF_WR_MODE: begin
                    if (fire != '0) begin
                        st_r <= ASF_CMD;
                        cnt_r <= 6'h00;
                    end else begin
                        cnt_r <= cnt_r + 6'h01;
                    end
                end
                ASF_SKIP_RD, ASF_SKIP: begin
                    st_r <= st_r;
                end
            endcase
        end
    end

    // last bit of each transaction kind
    // an event fires only once the whole transfer has gone by, so a
    // frame cut early neither sets ready nor clears the crc flag
    always_comb begin
        fire = '0;
        fire[EV_STAT] = (st_r == ASF_RD_STAT) &&
                        (cnt_r == last_bit(st_r, snap_r[32])); // R08
        fire[EV_DATA] = (st_r == ASF_RD_DATA) &&
                        (cnt_r == last_bit(st_r, snap_r[32])); // R04 R14
        fire[EV_MODE] = (st_r == ASF_WR_MODE) &&
                        (cnt_r == last_bit(st_r, snap_r[32])); // R17
    end

    // event toggles outlive the frame, so only device reset clears them
    // the host must keep select low past the last rising clock edge
    always_ff @(posedge sclk_in or negedge rst_n) begin
        if (!rst_n) begin
            tog_r <= '0;
        end else begin
            tog_r <= tog_r ^ (fire & {NEV{~cs_n_in}});
        end
    end

    // shift-out on the falling edge, host samples on rising
    always_ff @(negedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            rd_on_r <= 1'b0;
            out_r <= 1'b0;
        end else begin
            rd_on_r <= is_read(st_r); // R01
            if (st_r == ASF_RD_STAT) begin
                out_r <= snap_r[3'h7 - cnt_r[2:0]]; // R18
            end else begin
                out_r <= snap_r[5'h1F - cnt_r[4:0]]; // R14
            end
        end
    end

    // pin: read bit while reading, else live ready flag
    // the drive enable follows the synchronised select, so it lags
    // the pin by two device clocks; reads of other registers float
    assign dout_out = rd_on_r ? out_r : rdy_r; // R01
    assign dout_oe_out = ~cs_sync_r &
                         (st_r != ASF_SKIP_RD); // R01

endmodule : asf_status
`default_nettype wire

// ==== tb/asf_status_props.sv ====
// port assertions for the status flag block
`timescale 1ns/1ns
`default_nettype none
module asf_status_props (
    input wire logic clk_sys_in, // device clock
    input wire logic reset_n_in, // reset, active low
    input wire asf_pkg::asf_result_s result_in, // result
    input wire logic result_wr_in, // result strobe
    input wire logic cal_mode_in, // calibration mode
    input wire logic cal_done_in, // calibration strobe
    input wire logic crc_fail_in, // crc fail strobe
    input wire logic reg_check_en_in, // check enable
    input wire asf_pkg::asf_status_s status_out, // status
    input wire logic [23:0] data_out, // data register
    input wire logic mode_wr_out // mode write pulse
);
    import asf_pkg::*;
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (!reset_n_in);
    // result written outside calibration
    sequence res_wr;
        result_wr_in && !cal_mode_in;
    endsequence
    // out of range result
    sequence res_bad;
        res_wr ##0 (result_in.ovr || result_in.unr);
    endsequence
    chk_rdy_clear: assert property (res_wr |=> !status_out.rdy)
        else $error("rdy kept");
    chk_cal_clear: assert property (cal_mode_in && cal_done_in
        |=> !status_out.rdy) else $error("cal rdy kept");
    chk_range_set: assert property (res_bad |=> status_out.adc_err)
        else $error("range flag unset");
    chk_range_hold: assert property (!result_wr_in
        |=> $stable(status_out.adc_err)) else $error("range flag moved");
    chk_chan_field: assert property (res_wr
        |=> status_out.chan == $past(result_in.chan)) else $error("chan");
    chk_clamp_high: assert property (res_wr ##0 result_in.ovr
        |=> data_out == 24'hFFFFFF) else $error("clamp");
    chk_crc_set: assert property (crc_fail_in |=> status_out.crc_err)
        else $error("crc flag unset");
    chk_reg_clear: assert property (!reg_check_en_in
        |=> !status_out.reg_err) else $error("reg flag kept");
    chk_mode_ready: assert property (mode_wr_out
        |-> ##[0:1] status_out.rdy) else $error("mode rdy");
endmodule : asf_status_props
bind asf_status asf_status_props chk_u (.clk_sys_in, .reset_n_in,
    .result_in, .result_wr_in, .cal_mode_in, .cal_done_in,
    .crc_fail_in, .reg_check_en_in, .status_out, .data_out,
    .mode_wr_out);
`default_nettype wire

// ==== tb/asf_host.sv ====
// host model on the serial link, mode 3
`timescale 1ns/1ns
`default_nettype none
module asf_host (
    output logic sclk_out, // serial clock, idles high
    output logic cs_n_out, // chip select
    output logic din_out, // data to device
    input wire logic dout_in // data-out / ready pin
);
    // deselected, clock still between frames
    initial begin
        sclk_out = 1'b1;
        cs_n_out = 1'b1;
        din_out = 1'b0;
    end
    // one frame: command byte, then n bits each way
    task xfer(input logic [7:0] cmd, input int n,
        input logic [31:0] wd, output logic [31:0] rd);
        logic [39:0] sh;
        sh = {cmd, wd << (32 - n)};
        rd = 32'h0;
        cs_n_out = 1'b0;
        #200;
        for (int i = 0; i < 8 + n; i++) begin
            #62 sclk_out = 1'b0;
            din_out = sh[39 - i];
            #63 sclk_out = 1'b1;
            if (i >= 8) rd = {rd[30:0], dout_in}; // no crc byte
        end
        din_out = ~din_out;
        #62 cs_n_out = 1'b1;
        #200;
    endtask : xfer
endmodule : asf_host
`default_nettype wire

// ==== tb/asf_status_tb.sv ====
// self-checking bench for the status flag block
`timescale 1ns/1ns
`default_nettype none
module asf_status_tb;
    import asf_pkg::*;
    logic clk_sys_in, reset_n_in, result_wr_in, cal_mode_in;
    logic cal_done_in, crc_fail_in, reg_check_en_in;
    logic reg_mismatch_in, data_stat_en_in;
    logic dout_out, dout_oe_out, mode_wr_out;
    logic [23:0] data_out;
    logic [31:0] rd;
    asf_result_s result_in;
    asf_status_s status_out;
    wire logic sclk_in, cs_n_in, din_in;
    int err_count = 0;
    int checks = 0;
    int cycles = 0;
    // rows: result, data register, range flag
    asf_result_s rv[4] = '{30'h00123456, 30'h2F000001,
        30'h15800000, 30'h090ABCDE};
    logic [23:0] dv[4] = '{24'h123456, 24'hFFFFFF, 24'h000000,
        24'h0ABCDE};
    logic [3:0] ev = 4'h6;
    asf_status dut_u (.clk_sys_in, .reset_n_in, .sclk_in, .cs_n_in,
        .din_in, .dout_out, .dout_oe_out, .result_in, .result_wr_in,
        .cal_mode_in, .cal_done_in, .crc_fail_in, .reg_check_en_in,
        .reg_mismatch_in, .data_stat_en_in, .status_out, .data_out,
        .mode_wr_out);
    asf_host host_u (.sclk_out(sclk_in), .cs_n_out(cs_n_in),
        .din_out(din_in), .dout_in(dout_oe_out ? dout_out : ~dout_out));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task conclude();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    // one result strobe, settled on return
    task post(input asf_result_s r);
        @(posedge clk_sys_in) result_in <= r;
        result_wr_in <= 1'b1;
        @(posedge clk_sys_in) result_wr_in <= 1'b0;
        @(posedge clk_sys_in) #1;
    endtask : post
    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    // hang guard
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        {reset_n_in, result_wr_in, cal_mode_in, cal_done_in} = 4'h0;
        {crc_fail_in, reg_check_en_in, reg_mismatch_in} = 3'h0;
        data_stat_en_in = 1'b0;
        result_in = '0;
        repeat (8) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        #1 chk({status_out, data_out}, 32'h80000000);
        // four results, one over and one under range, each read back
        for (int i = 0; i < 4; i++) begin
            post(rv[i]);
            chk({status_out.rdy, status_out.adc_err, status_out.chan,
                data_out}, {1'b0, ev[i], rv[i].chan, dv[i]});
            host_u.xfer(8'h44, 24, 32'h0, rd);
            chk(rd, dv[i]);
            repeat (3) @(posedge clk_sys_in);
            #1 chk(status_out.rdy, 1'b1);
        end
        // ready on the idle pin, status after data
        @(posedge clk_sys_in) data_stat_en_in <= 1'b1;
        post(30'h03ABCDEF);
        fork
            host_u.xfer(8'h44, 32, 32'h0, rd);
            #150 chk({dout_oe_out, dout_out}, 2'h2);
        join
        chk(rd, 32'hABCDEF03);
        // crc flag seen by a read, then cleared
        @(posedge clk_sys_in) crc_fail_in <= 1'b1;
        data_stat_en_in <= 1'b0;
        @(posedge clk_sys_in) crc_fail_in <= 1'b0;
        host_u.xfer(8'h40, 8, 32'h0, rd);
        chk(rd, 32'hA3);
        repeat (3) @(posedge clk_sys_in);
        #1 chk(status_out.crc_err, 1'b0);
        // mode write brings ready back
        post(30'h07000010);
        host_u.xfer(8'h01, 16, 32'h2000, rd);
        repeat (3) @(posedge clk_sys_in);
        #1 chk(status_out.rdy, 1'b1);
        // read of another register: pin left undriven
        fork
            host_u.xfer(8'h47, 8, 32'h0, rd);
            #1300 chk(dout_oe_out, 1'b0);
        join
        // calibration: only its own strobe clears ready
        @(posedge clk_sys_in) cal_mode_in <= 1'b1;
        post(30'h02000055);
        chk(status_out.rdy, 1'b1);
        @(posedge clk_sys_in) cal_done_in <= 1'b1;
        @(posedge clk_sys_in) cal_done_in <= 1'b0;
        reg_check_en_in <= 1'b1;
        reg_mismatch_in <= 1'b1;
        @(posedge clk_sys_in) reg_mismatch_in <= 1'b0;
        cal_mode_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        #1 chk({status_out.rdy, status_out.reg_err}, 2'h1);
        @(posedge clk_sys_in) reg_check_en_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        #1 chk(status_out.reg_err, 1'b0);
        conclude();
    end
endmodule : asf_status_tb
`default_nettype wire
